// >>> logic/eip_pkg.sv
// Constants, state type and per-source qualifier for the interrupt front end.
`timescale 1ns/100ps
package eip_pkg;
  localparam int unsigned NUM_SRC       = 5;
  localparam int unsigned IDX_W         = 3;
  localparam logic [2:0]  SRC_ZERO      = 3'h0;
  localparam logic [2:0]  SRC_ONE       = 3'h1;
  localparam logic [2:0]  SRC_TWO       = 3'h2;
  localparam logic [2:0]  SRC_THREE     = 3'h3;
  localparam logic [2:0]  SRC_FOUR      = 3'h4;
  localparam logic [7:0]  VEC_ZERO      = 8'h0C;
  localparam logic [7:0]  VEC_ONE       = 8'h0D;
  localparam logic [7:0]  VEC_TWO       = 8'h0E;
  localparam logic [7:0]  VEC_THREE     = 8'h0F;
  localparam logic [7:0]  VEC_FOUR      = 8'h11;
  localparam logic [7:0]  VEC_RESET     = 8'h00;
  localparam logic [4:0]  NONE_PEND     = 5'h00;
  localparam logic [4:0]  ONE_HOT_LSB   = 5'h01;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned ACK_TIME_NS   = 10;
  localparam int unsigned ACK_CYCLES    =
    (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  ACK_CNT_LAST  = 3'(ACK_CYCLES - 1);
  localparam logic [2:0]  ACK_CNT_ZERO  = 3'h0;

  typedef enum logic [2:0] {
    EIP_IDLE = 3'b001,
    EIP_REQ  = 3'b010,
    EIP_ACK  = 3'b100
  } eip_state_t;
endpackage

module eip_src_qual
  import eip_pkg::*;
(
  // Request line and its qualifiers.
  input  wire logic req_i,
  input  wire logic mask_i,
  input  wire logic as_ack_i,
  // Qualified request.
  output logic      pend_o
);
  // A masked line, or a pin lent to an acknowledge, never raises a request.
  assign pend_o = req_i & ~mask_i & ~as_ack_i; // see RULE_02 see RULE_03
endmodule

// >>> logic/eip_irq_front.sv
// External interrupt pin front end with cascade acknowledge handshake.
//
// Behaviour
// RULE_01: Each request line maps to fixed vector type.
// RULE_02: Requests are active high and individually maskable.
// RULE_03: Cascade mode turns lines two, three into acknowledges.
// RULE_04: Servicing line zero pulses acknowledge zero low.
// RULE_05: Servicing line one pulses acknowledge one low.
// RULE_06: Simultaneous requests served lowest-numbered line first.
`timescale 1ns/100ps
module eip_irq_front
  import eip_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  // Request pins.
  input  wire logic       irq_in_zero_i,
  input  wire logic       irq_in_one_i,
  input  wire logic       irq_in_two_i,
  input  wire logic       irq_in_three_i,
  input  wire logic       irq_in_four_i,
  // Shared pins driven as acknowledges in cascade mode.
  output logic            irq_ack_zero_low_o,
  output logic            irq_ack_zero_oe_n_o,
  output logic            irq_ack_one_low_o,
  output logic            irq_ack_one_oe_n_o,
  // Configuration from the interrupt unit.
  input  wire logic [4:0] irq_mask_i,
  input  wire logic       cascade_mode_i,
  // Request towards the processor core.
  output logic            req_valid_o,
  output logic [7:0]      vec_type_o,
  output logic [2:0]      src_idx_o,
  input  wire logic       svc_ack_i
);
  eip_state_t  state_q, state_d;
  logic [2:0]  idx_q, idx_d;
  logic [7:0]  vec_q, vec_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        ack0_n_q, ack0_n_d;
  logic        ack1_n_q, ack1_n_d;
  logic        oe_n_q, oe_n_d;
  logic [4:0]  pin_vec;
  logic [4:0]  lent_vec;
  logic [4:0]  pend_vec;
  logic [2:0]  sel_idx;
  logic        pend_any;

  function automatic logic [7:0] vec_lut(input logic [2:0] idx);
    case (idx)
      SRC_ZERO:  vec_lut = VEC_ZERO;
      SRC_ONE:   vec_lut = VEC_ONE;
      SRC_TWO:   vec_lut = VEC_TWO;
      SRC_THREE: vec_lut = VEC_THREE;
      default:   vec_lut = VEC_FOUR;
    endcase
  endfunction

  assign pin_vec  = {irq_in_four_i, irq_in_three_i, irq_in_two_i,
                     irq_in_one_i, irq_in_zero_i};
  assign lent_vec = {1'b0, cascade_mode_i, cascade_mode_i, 1'b0, 1'b0};

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gen_src
      eip_src_qual u_qual (
        .req_i    (pin_vec[g]),
        .mask_i   (irq_mask_i[g]),
        .as_ack_i (lent_vec[g]),
        .pend_o   (pend_vec[g])
      );
    end
  endgenerate

  // Lowest-numbered pending line wins.
  always_comb begin
    sel_idx  = SRC_FOUR;
    pend_any = (pend_vec != NONE_PEND);
    for (int i = NUM_SRC - 1; i >= 0; i--) begin // see RULE_06
      if (pend_vec[i]) begin
        sel_idx = 3'(i);
      end
    end
  end

  // The chosen line is held until the core accepts it; a line that drops
  // meanwhile is still delivered, so sources need not hold until serviced.
  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    vec_d   = vec_q;
    cnt_d   = cnt_q;
    case (state_q)
      EIP_IDLE: begin
        if (pend_any) begin
          state_d = EIP_REQ;
          idx_d   = sel_idx;
          vec_d   = vec_lut(sel_idx); // see RULE_01
        end
      end
      EIP_REQ: begin
        if (svc_ack_i) begin
          if (cascade_mode_i && (idx_q == SRC_ZERO || idx_q == SRC_ONE)) begin
            state_d = EIP_ACK; // see RULE_04 see RULE_05
            cnt_d   = ACK_CNT_ZERO;
          end else begin
            state_d = EIP_IDLE;
          end
        end
      end
      EIP_ACK: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == ACK_CNT_LAST) begin
          state_d = EIP_IDLE;
          cnt_d   = ACK_CNT_ZERO;
        end
      end
      default: begin
        state_d = EIP_IDLE;
      end
    endcase
    ack0_n_d = !(state_d == EIP_ACK && idx_d == SRC_ZERO); // see RULE_04
    ack1_n_d = !(state_d == EIP_ACK && idx_d == SRC_ONE);  // see RULE_05
    oe_n_d   = !cascade_mode_i; // see RULE_03
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_q  <= EIP_IDLE;
      idx_q    <= SRC_ZERO;
      vec_q    <= VEC_RESET;
      cnt_q    <= ACK_CNT_ZERO;
      ack0_n_q <= 1'b1;
      ack1_n_q <= 1'b1;
      oe_n_q   <= 1'b1;
    end else begin
      state_q  <= state_d;
      idx_q    <= idx_d;
      vec_q    <= vec_d;
      cnt_q    <= cnt_d;
      ack0_n_q <= ack0_n_d;
      ack1_n_q <= ack1_n_d;
      oe_n_q   <= oe_n_d;
    end
  end

  assign req_valid_o         = (state_q == EIP_REQ);
  assign vec_type_o          = vec_q;
  assign src_idx_o           = idx_q;
  assign irq_ack_zero_low_o  = ack0_n_q;
  assign irq_ack_one_low_o   = ack1_n_q;
  assign irq_ack_zero_oe_n_o = oe_n_q;
  assign irq_ack_one_oe_n_o  = oe_n_q;

  sequence svc_zero_s;
    req_valid_o && svc_ack_i && cascade_mode_i && idx_q == SRC_ZERO;
  endsequence

  sequence svc_one_s;
    req_valid_o && svc_ack_i && cascade_mode_i && idx_q == SRC_ONE;
  endsequence

  sequence ack_zero_pulse_s;
    !irq_ack_zero_low_o [*2] ##1 irq_ack_zero_low_o;
  endsequence

  sequence ack_one_pulse_s;
    !irq_ack_one_low_o [*2] ##1 irq_ack_one_low_o;
  endsequence

  vector_type_a: assert property ( // see RULE_01
    @(posedge sys_clk_i) disable iff (srst_i)
    req_valid_o |->
      (idx_q == SRC_ZERO  && vec_type_o == VEC_ZERO)  ||
      (idx_q == SRC_ONE   && vec_type_o == VEC_ONE)   ||
      (idx_q == SRC_TWO   && vec_type_o == VEC_TWO)   ||
      (idx_q == SRC_THREE && vec_type_o == VEC_THREE) ||
      (idx_q == SRC_FOUR  && vec_type_o == VEC_FOUR))
    else $error("Vector type does not match serviced line.");

  req_hold_a: assert property ( // see RULE_01
    @(posedge sys_clk_i) disable iff (srst_i)
    req_valid_o && !svc_ack_i |=>
      req_valid_o && $stable(vec_type_o) && $stable(src_idx_o))
    else $error("Request dropped or changed before acceptance.");

  mask_honoured_a: assert property ( // see RULE_02
    @(posedge sys_clk_i) disable iff (srst_i)
    $rose(req_valid_o) |->
      ((ONE_HOT_LSB << idx_q) & $past(irq_mask_i)) == NONE_PEND)
    else $error("Masked line raised a request.");

  lent_pins_a: assert property ( // see RULE_03
    @(posedge sys_clk_i) disable iff (srst_i)
    $rose(req_valid_o) && $past(cascade_mode_i) |->
      idx_q != SRC_TWO && idx_q != SRC_THREE)
    else $error("Acknowledge pin taken as a request.");

  pin_enable_a: assert property ( // see RULE_03
    @(posedge sys_clk_i) disable iff (srst_i)
    cascade_mode_i |=> !irq_ack_zero_oe_n_o && !irq_ack_one_oe_n_o)
    else $error("Acknowledge pins not driven in cascade mode.");

  ack_zero_a: assert property ( // see RULE_04
    @(posedge sys_clk_i) disable iff (srst_i)
    svc_zero_s |=> ack_zero_pulse_s)
    else $error("Acknowledge zero pulse wrong.");

  ack_one_a: assert property ( // see RULE_05
    @(posedge sys_clk_i) disable iff (srst_i)
    svc_one_s |=> ack_one_pulse_s)
    else $error("Acknowledge one pulse wrong.");

  ack_source_a: assert property ( // see RULE_04
    @(posedge sys_clk_i) disable iff (srst_i)
    !irq_ack_zero_low_o |-> idx_q == SRC_ZERO && irq_ack_one_low_o)
    else $error("Acknowledge zero for wrong line.");

  priority_order_a: assert property ( // see RULE_06
    @(posedge sys_clk_i) disable iff (srst_i)
    $rose(req_valid_o) |->
      ($past(pend_vec) & ((ONE_HOT_LSB << idx_q) - ONE_HOT_LSB)) == NONE_PEND)
    else $error("Lower-numbered pending line was skipped.");
endmodule

// >>> tb/eip_src_model.sv
// Model of the external request sources, cascaded on lines zero and one.
`timescale 1ns/100ps
module eip_src_model (
  // Clock, reset and bench controls.
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  input  wire logic [4:0] start_i,
  input  wire logic [4:0] drop_i,
  // Acknowledges in, request lines out.
  input  wire logic [1:0] ack_low_i,
  output logic      [4:0] irq_o
);
  logic [4:0] req_q;
  assign irq_o = req_q;
  // A cascaded source holds its line until it sees its acknowledge or its drop_i bit.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      req_q <= 5'h00;
    end else begin
      req_q <= (req_q | start_i) & ~drop_i
               & {3'h7, ack_low_i};
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the interrupt pin front end.
`timescale 1ns/100ps
module tb;
  import eip_pkg::*;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [4:0] mask = 5'h00;
  logic       casc = 1'b0;
  logic       svc = 1'b0;
  logic [4:0] start = 5'h00;
  logic [4:0] drop = 5'h00;
  logic [4:0] irq;
  logic [1:0] ack_n;
  logic [1:0] oe_n;
  logic       valid;
  logic       w2;
  logic       w3;
  logic [7:0] vec;
  logic [2:0] idx;
  int         errors = 0;
  int         n_compared = 0;
  int         cyc = 0;
  // Shared pins carry the acknowledge while the device drives them.
  assign w2 = oe_n[0] ? irq[2] : ack_n[0];
  assign w3 = oe_n[1] ? irq[3] : ack_n[1];
  eip_src_model src_u (.sys_clk_i(clk), .srst_i(srst), .start_i(start),
    .drop_i(drop), .ack_low_i(ack_n), .irq_o(irq));
  eip_irq_front dut_u (.sys_clk_i(clk), .srst_i(srst),
    .irq_in_zero_i(irq[0]), .irq_in_one_i(irq[1]), .irq_in_two_i(w2),
    .irq_in_three_i(w3), .irq_in_four_i(irq[4]),
    .irq_ack_zero_low_o(ack_n[0]), .irq_ack_zero_oe_n_o(oe_n[0]),
    .irq_ack_one_low_o(ack_n[1]), .irq_ack_one_oe_n_o(oe_n[1]),
    .irq_mask_i(mask), .cascade_mode_i(casc), .req_valid_o(valid),
    .vec_type_o(vec), .src_idx_o(idx), .svc_ack_i(svc));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      final_report();
    end
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [2:0] first_src(logic [4:0] r);
    for (int i = 0; i < 5; i++) begin
      if (r[i]) return 3'(i);
    end
    return 3'h7;
  endfunction
  // Fixed vector types: lines zero to three give 12 to 15, line four 17.
  function automatic logic [7:0] vec_of(logic [2:0] i);
    return (i == 3'h4) ? 8'h11 : 8'h0C + 8'(i);
  endfunction
  task automatic fire(logic [4:0] b, logic [4:0] dr, logic [4:0] m);
    @(posedge clk) start <= b;
    mask <= m;
    @(posedge clk) start <= 5'h00;
    drop <= dr;
    @(posedge clk) drop <= 5'h00;
  endtask
  task automatic serve(logic [2:0] ei);
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 6) begin
      @(negedge clk);
      n++;
    end
    if (ei == 3'h7) begin
      chk("valid", 8'h00, 8'(valid));
      return;
    end
    chk("valid", 8'h01, 8'(valid));
    chk("vec", vec_of(ei), vec);
    chk("idx", 8'(ei), 8'(idx));
    @(posedge clk) svc <= 1'b1;
    @(posedge clk) svc <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      chk("ack", (casc && k < 2 && ei < 3'h2) ? 8'h03 & ~(8'h01 << ei)
        : 8'h03, 8'(ack_n));
    end
  endtask
  initial begin
    logic [4:0] b;
    logic [4:0] m;
    void'($urandom(21768));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("rst", 8'h0F, 8'({valid, ack_n, oe_n}));
    for (int k = 0; k < 6; k++) begin
      m = 5'((6'h01 << k) - 6'h01);
      fire(5'h1F, 5'h1F, m);
      serve(first_src(~m));
    end
    for (int k = 0; k < 30; k++) begin
      b = 5'($urandom);
      m = 5'($urandom);
      fire(b, 5'h1F, m);
      serve(first_src(b & ~m));
    end
    @(posedge clk) casc <= 1'b1;
    // The enables are registered, so they follow the mode one edge later.
    repeat (2) @(negedge clk);
    chk("oe", 8'h00, 8'(oe_n));
    for (int i = 0; i < 2; i++) begin
      fire(5'h1C | 5'(1 << i), 5'h1C, 5'h00);
      serve(3'(i));
    end
    fire(5'h1C, 5'h1C, 5'h00);
    serve(3'h4);
    final_report();
  end
endmodule
